// File: hdl/hwd_watchdog.sv
// Hardware watchdog with prescaler, service key register and reset pulse output
`timescale 1ns/10ps
`default_nettype none

// Behaviour
// - After any reset the watchdog is off, does not count and makes no reset until enabled.
// - Writing 0x1e then 0xe1 to the service key register enables the watchdog.
// - While enabled the counter advances by one every machine cycle while the clock runs.
// - Once enabled it cannot be turned off except by a hardware or watchdog reset.
// - Overflow of the 14-bit count at 0x3fff resets the whole device.
// - The key sequence while running restarts the counter from zero.
// - The key register is write-only and the counter is neither readable nor writable.
// - On overflow an active-low reset pulse of 96 peripheral clock periods is driven.
// - A 7-stage prescale chain extends the timeout range.
// - The 3-bit select field sets the timeout to 16384 times two to its value cycles.
// - The select field resets to zero and its upper five bits are not stored and read as zero.
// - In power-down the clock halts and the counter stops advancing.
// - After power-down exit by interrupt, counting waits while the interrupt pin is low.
module hwd_watchdog (
    input wire logic core_clk_in, // 20 MHz core clock, one machine cycle per edge
    input wire logic rst_in, // Synchronous active-high reset
    input wire logic machine_cycle_in, // Machine cycle strobe from core timing
    input wire logic power_down_in, // Core is in power-down, clock gated
    input wire logic wake_int_n_in, // External wake interrupt pin, active low
    input wire logic [9:0] avs_address_in, // Avalon byte address
    input wire logic avs_read_in, // Avalon read
    input wire logic avs_write_in, // Avalon write
    input wire logic [31:0] avs_writedata_in, // Avalon write data
    input wire logic [3:0] avs_byteenable_in, // Avalon byte enables
    output logic [31:0] avs_readdata_out, // Avalon read data
    output logic avs_waitrequest_out, // Avalon wait request
    output logic [1:0] avs_response_out, // Avalon response, slave error on unmapped
    output logic device_rst_n_out, // Active-low reset pulse to the device
    output logic device_rst_oe_out // Drive enable of the reset pin
);
    import hwd_pkg::*;

    hwd_state_t state;
    hwd_bus_req_t req;
    logic [HWD_SEL_W-1:0] timeout_sel;
    logic [HWD_CNT_W-1:0] count;
    logic [HWD_PULSE_W-1:0] pulse_cnt;
    logic pulse_active;
    logic wake_s1, wake_s2, wake_s3, wake_ok;
    logic wake_hold;
    logic served;
    logic acked;
    logic key_wr, sel_wr, stat_rd, mapped;
    logic running, overflow, advance;
    logic [HWD_CNT_W-1:0] limit;

    assign req = '{address: avs_address_in, read: avs_read_in, write: avs_write_in,
                   writedata: avs_writedata_in};

    // Address decode; one wait cycle per access keeps timing fixed
    always_comb begin
        mapped = 1'b0;
        if (req.address == HWD_ADDR_SERVICE_KEY) begin
            mapped = 1'b1;
        end else if (req.address == HWD_ADDR_TIMEOUT_SEL) begin
            mapped = 1'b1;
        end else if (req.address == HWD_ADDR_STATUS) begin
            mapped = 1'b1;
        end
    end
    assign avs_waitrequest_out = (req.read | req.write) & ~acked;
    assign key_wr = req.write & acked & avs_byteenable_in[0]
                    & (req.address == HWD_ADDR_SERVICE_KEY);
    assign sel_wr = req.write & acked & avs_byteenable_in[0]
                    & (req.address == HWD_ADDR_TIMEOUT_SEL);
    assign stat_rd = req.address == HWD_ADDR_STATUS;

    // Acknowledge pulse, cleared after each completed access
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            acked <= 1'b0;
        end else begin
            acked <= (req.read | req.write) & ~acked;
        end
    end

    // Read data; the key register and the counter never read back
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            avs_readdata_out <= 32'h0;
            avs_response_out <= 2'h0;
        end else if ((req.read | req.write) & ~acked) begin
            avs_readdata_out <= 32'h0;
            avs_response_out <= mapped ? 2'h0 : 2'h2;
            if (req.read & (req.address == HWD_ADDR_TIMEOUT_SEL)) begin
                avs_readdata_out <= {29'h0, timeout_sel};
            end else if (req.read & stat_rd) begin
                avs_readdata_out <= {29'h0, pulse_active, state[0], state[1]};
            end
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            timeout_sel <= HWD_SEL_RESET;
        end else if (sel_wr) begin
            // Upper five bits are not stored, reads show zero
            timeout_sel <= req.writedata[HWD_SEL_W-1:0];
        end
    end

    always_ff @(posedge core_clk_in) begin
        if (rst_in | pulse_active) begin
            state <= HWD_OFF;
        end else if (key_wr) begin
            case (state)
                HWD_OFF: state <= (req.writedata[7:0] == HWD_KEY_FIRST) ? HWD_OFF_ARMED : HWD_OFF;
                HWD_OFF_ARMED: begin
                    if (req.writedata[7:0] == HWD_KEY_SECOND) begin
                        state <= HWD_RUN;
                    end else if (req.writedata[7:0] == HWD_KEY_FIRST) begin
                        state <= HWD_OFF_ARMED;
                    end else begin
                        state <= HWD_OFF;
                    end
                end
                // no way back to off by software
                HWD_RUN: state <= (req.writedata[7:0] == HWD_KEY_FIRST) ? HWD_RUN_ARMED : HWD_RUN;
                HWD_RUN_ARMED: begin
                    if (req.writedata[7:0] == HWD_KEY_FIRST) begin
                        state <= HWD_RUN_ARMED;
                    end else begin
                        state <= HWD_RUN;
                    end
                end
                default: state <= HWD_OFF;
            endcase
        end
    end
    assign running = state[1];
    assign served = key_wr & (state == HWD_RUN_ARMED)
                    & (req.writedata[7:0] == HWD_KEY_SECOND);

    // Wake pin through three flops; a change counts when the last two agree
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            wake_s1 <= 1'b1;
            wake_s2 <= 1'b1;
            wake_s3 <= 1'b1;
            wake_ok <= 1'b1;
        end else begin
            wake_s1 <= wake_int_n_in;
            wake_s2 <= wake_s1;
            wake_s3 <= wake_s2;
            if (wake_s2 == wake_s3) begin
                wake_ok <= wake_s3;
            end
        end
    end

    // hold after power-down exit until the pin is high
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            wake_hold <= 1'b0;
        end else if (power_down_in) begin
            wake_hold <= 1'b1;
        end else if (wake_ok) begin
            wake_hold <= 1'b0;
        end
    end

    assign advance = running & machine_cycle_in & ~power_down_in & ~wake_hold & ~pulse_active;

    // limit is 16384 times two to the select value, minus one
    assign limit = HWD_CNT_W'({HWD_MAIN_TOP, {HWD_PRE_W{1'b1}}} >> (HWD_PRE_W - int'(timeout_sel)));
    // overflow at or above the top, so a select shortened mid-run still trips
    assign overflow = advance & (count >= limit);

    always_ff @(posedge core_clk_in) begin
        if (rst_in | ~running) begin
            count <= '0;
        end else if (served | overflow) begin
            count <= '0;
        end else if (advance) begin
            count <= count + 1'b1;
        end
    end

    // reset pulse of 96 peripheral clocks
    always_ff @(posedge core_clk_in) begin
        if (rst_in) begin
            pulse_active <= 1'b0;
            pulse_cnt <= '0;
        end else if (overflow) begin
            pulse_active <= 1'b1;
            pulse_cnt <= HWD_PULSE_W'(HWD_RST_PULSE_CYC - 1);
        end else if (pulse_active) begin
            if (pulse_cnt == '0) begin
                pulse_active <= 1'b0;
            end else begin
                pulse_cnt <= pulse_cnt - 1'b1;
            end
        end
    end
    // Open-drain style: pin driven only while pulling low
    assign device_rst_n_out = ~pulse_active;
    assign device_rst_oe_out = pulse_active;

    // Pulse high on the first 8 cycles after overflow and at cycle 96, low at cycle 97
    sequence ovf_s;
        overflow;
    endsequence
    pulse_len_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        ovf_s |=> device_rst_oe_out[*8] ##88 device_rst_oe_out ##1 !device_rst_oe_out)
        else $error("reset pulse length wrong");
    off_quiet_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        !running |-> !overflow && count == '0)
        else $error("counting while disabled");
    enable_key_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (state == HWD_OFF_ARMED && key_wr && req.writedata[7:0] == HWD_KEY_SECOND
         && !pulse_active) |=> running)
        else $error("key sequence did not enable");
    count_step_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (advance && !served && !overflow) |=> count == $past(count) + 1'b1)
        else $error("counter did not advance");
    stay_on_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (running && !pulse_active && !overflow) |=> running)
        else $error("watchdog turned off by software");
    service_clear_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        served && !overflow |=> count == '0)
        else $error("service did not restart counter");
    pd_hold_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        power_down_in |=> $stable(count) || count == '0)
        else $error("counting in power-down");
    bad_key_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (state == HWD_OFF_ARMED && key_wr && req.writedata[7:0] != HWD_KEY_SECOND
         && !pulse_active) |=> !running)
        else $error("bad key enabled watchdog");
    // while the synced pin stays low after power-down, the count holds
    wake_wait_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (wake_hold && !wake_ok && !power_down_in)
        |=> wake_hold && ($stable(count) || count == '0))
        else $error("counting while wake pin low");

    // every reset release leaves the pin quiet and the watchdog off
    reset_quiet_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        $fell(rst_in) |-> device_rst_n_out && !device_rst_oe_out && !running)
        else $error("watchdog active after reset");
    // select field back at its shortest value after reset
    sel_reset_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        $fell(rst_in) |-> timeout_sel == HWD_SEL_RESET)
        else $error("select field not cleared by reset");
    // a select write lands in the stored field
    sel_write_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        sel_wr |=> timeout_sel == $past(req.writedata[HWD_SEL_W-1:0]))
        else $error("select write lost");
    // overflow only once the scaled count has reached the top
    top_count_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        overflow |-> (count >> timeout_sel) >= HWD_CNT_W'(HWD_MAIN_TOP))
        else $error("overflow before the selected timeout");
    // below the scaled top an advancing count never overflows
    early_ovf_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (advance && (count >> timeout_sel) < HWD_CNT_W'(HWD_MAIN_TOP)) |-> !overflow)
        else $error("early overflow");

    // Key bytes as seen on a completing write to the service register
    sequence key_first_s;
        key_wr && req.writedata[7:0] == HWD_KEY_FIRST;
    endsequence
    sequence key_second_s;
        key_wr && req.writedata[7:0] == HWD_KEY_SECOND;
    endsequence
    // first byte arms a running watchdog, second byte restarts it
    arm_run_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (state == HWD_RUN && !pulse_active) ##0 key_first_s |=> state == HWD_RUN_ARMED)
        else $error("first key byte did not arm");
    restart_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (state == HWD_RUN_ARMED && !pulse_active) ##0 key_second_s |=> running && count == '0)
        else $error("second key byte did not restart");

    // Every access waits exactly one cycle, so software timing stays fixed
    sequence bus_start_s;
        (avs_read_in || avs_write_in) && !acked;
    endsequence
    one_wait_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        bus_start_s |-> avs_waitrequest_out ##1 !avs_waitrequest_out)
        else $error("wait state count wrong");
    // the service key reads back as zero
    key_read_zero_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        (bus_start_s ##0 (avs_read_in && req.address == HWD_ADDR_SERVICE_KEY))
        |=> avs_readdata_out == '0)
        else $error("service key read back data");
    // when a pulse ends the watchdog is off, never earlier by software
    pulse_end_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
        $fell(pulse_active) |-> !running)
        else $error("still running after overflow pulse");
endmodule

`default_nettype wire

// File: inc/hwd_pkg.sv
// Package with register map, field layout and timing constants for the watchdog
`default_nettype none
package hwd_pkg;
    // Register byte addresses: the register index times four
    localparam logic [7:0] HWD_IDX_SERVICE_KEY = 8'ha6;
    localparam logic [7:0] HWD_IDX_TIMEOUT_SEL = 8'ha7;
    localparam logic [9:0] HWD_ADDR_SERVICE_KEY = {HWD_IDX_SERVICE_KEY, 2'b00};
    localparam logic [9:0] HWD_ADDR_TIMEOUT_SEL = {HWD_IDX_TIMEOUT_SEL, 2'b00};
    localparam logic [9:0] HWD_ADDR_STATUS = 10'h2a0;
    // Service key bytes
    localparam logic [7:0] HWD_KEY_FIRST = 8'h1e;
    localparam logic [7:0] HWD_KEY_SECOND = 8'he1;
    // Timeout select field
    localparam int HWD_SEL_W = 3;
    localparam logic [HWD_SEL_W-1:0] HWD_SEL_RESET = 3'h0;
    // Counter widths: 14-bit main counter plus 7-stage prescale chain
    localparam int HWD_MAIN_W = 14;
    localparam int HWD_PRE_W = 7;
    localparam int HWD_CNT_W = HWD_MAIN_W + HWD_PRE_W;
    localparam logic [HWD_MAIN_W-1:0] HWD_MAIN_TOP = 14'h3fff;
    // Reset pulse length in peripheral clock periods
    localparam int HWD_RST_PULSE_CYC = 96;
    localparam int HWD_PULSE_W = 7;
    // Status register bit positions
    localparam int HWD_ST_ENABLED = 0;
    localparam int HWD_ST_ARMED = 1;
    localparam int HWD_ST_PULSE = 2;

    // Bus request carrier
    typedef struct packed {
        logic [9:0] address;
        logic read;
        logic write;
        logic [31:0] writedata;
    } hwd_bus_req_t;

    // Key sequence states
    typedef enum logic [1:0] {
        HWD_OFF = 2'b00,
        HWD_OFF_ARMED = 2'b01,
        HWD_RUN = 2'b10,
        HWD_RUN_ARMED = 2'b11
    } hwd_state_t;
endpackage
`default_nettype wire

// File: verif/hwd_watchdog_tb_top.sv
// Self-checking testbench for the hardware watchdog block
`timescale 1ns/10ps
`default_nettype none
module hwd_watchdog_tb_top;
    import hwd_pkg::*;
    typedef struct packed {
        logic [9:0] addr;
        logic wr;
        logic [31:0] data;
        logic [31:0] exp_rd;
        logic [1:0] exp_resp;
    } hwd_row_t;
    logic core_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic power_down_in = 1'b0;
    logic wake_int_n_in = 1'b1;
    logic machine_cycle_in = 1'b1;
    hwd_bus_req_t req = '0;
    logic [31:0] avs_readdata_out;
    logic avs_waitrequest_out;
    logic [1:0] avs_response_out;
    logic device_rst_n_out;
    logic device_rst_oe_out;
    int num_errors = 0;
    int check_count = 0;
    logic [31:0] rd;
    logic [1:0] rs;
    int n;
    hwd_row_t rows [15];

    // Machine cycle strobe high except in the stall test: one machine cycle per clock
    hwd_watchdog hwd_watchdog_i (
        .core_clk_in(core_clk_in), .rst_in(rst_in), .machine_cycle_in(machine_cycle_in),
        .power_down_in(power_down_in), .wake_int_n_in(wake_int_n_in),
        .avs_address_in(req.address), .avs_read_in(req.read), .avs_write_in(req.write),
        .avs_writedata_in(req.writedata), .avs_byteenable_in(4'hf),
        .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
        .avs_response_out(avs_response_out), .device_rst_n_out(device_rst_n_out),
        .device_rst_oe_out(device_rst_oe_out));

    // Clock at 20 MHz
    initial forever #25 core_clk_in = ~core_clk_in;

    task automatic check(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask

    // One Avalon access; request held until waitrequest is sampled low on a rising edge
    task automatic bus(input logic [9:0] a, input logic w, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge core_clk_in);
        req <= '{address: a, read: !w, write: w, writedata: d};
        do begin
            @(posedge core_clk_in);
            k++;
        end while (avs_waitrequest_out !== 1'b0 && k < 20);
        // Answer taken at the completing edge, then the request is released
        rd = avs_readdata_out;
        rs = avs_response_out;
        req <= '0;
        check(k < 20, "bus access hung");
    endtask

    task automatic key();
        bus(HWD_ADDR_SERVICE_KEY, 1'b1, {24'h0, HWD_KEY_FIRST});
        bus(HWD_ADDR_SERVICE_KEY, 1'b1, {24'h0, HWD_KEY_SECOND});
    endtask

    // Reset pin must stay released and undriven for c cycles
    task automatic quiet(input int c);
        logic bad;
        bad = 1'b0;
        repeat (c) begin
            @(negedge core_clk_in);
            if (device_rst_n_out !== 1'b1 || device_rst_oe_out !== 1'b0) bad = 1'b1;
        end
        check(!bad, "reset pulse where none expected");
    endtask

    // Pulse must start within lo..hi cycles and last exactly the pulse length
    task automatic wait_pulse(input int lo, input int hi);
        n = 0;
        while (device_rst_n_out !== 1'b0 && n <= hi) begin
            @(negedge core_clk_in);
            n++;
        end
        check(n >= lo && n <= hi, "reset pulse start time");
        n = 0;
        while (device_rst_n_out === 1'b0 && device_rst_oe_out === 1'b1 && n < 200) begin
            @(negedge core_clk_in);
            n++;
        end
        check(n == HWD_RST_PULSE_CYC, "reset pulse length");
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // Hang guard, about 97k cycles, a little above the roughly 94k cycles of the sequence
    initial begin
        #4_850_000;
        num_errors++;
        $display("mismatch at %0t: run timed out", $time);
        stop_test();
    end

    // Main sequence
    initial begin
        rows = '{
            '{HWD_ADDR_TIMEOUT_SEL, 1'b0, 32'h0, 32'h0, 2'h0},
            '{HWD_ADDR_STATUS, 1'b0, 32'h0, 32'h0, 2'h0},
            '{HWD_ADDR_SERVICE_KEY, 1'b0, 32'h0, 32'h0, 2'h0},
            '{10'h000, 1'b0, 32'h0, 32'h0, 2'h2},
            '{HWD_ADDR_TIMEOUT_SEL, 1'b1, 32'h5, 32'h0, 2'h0},
            '{HWD_ADDR_TIMEOUT_SEL, 1'b0, 32'h0, 32'h5, 2'h0},
            '{10'h004, 1'b1, 32'hffffffff, 32'h0, 2'h2},
            '{HWD_ADDR_TIMEOUT_SEL, 1'b0, 32'h0, 32'h5, 2'h0},
            '{HWD_ADDR_SERVICE_KEY, 1'b1, 32'h1e, 32'h0, 2'h0},
            '{HWD_ADDR_STATUS, 1'b0, 32'h0, 32'h2, 2'h0},
            '{HWD_ADDR_SERVICE_KEY, 1'b1, 32'h55, 32'h0, 2'h0},
            '{HWD_ADDR_STATUS, 1'b0, 32'h0, 32'h0, 2'h0},
            '{HWD_ADDR_SERVICE_KEY, 1'b1, 32'he1, 32'h0, 2'h0},
            '{HWD_ADDR_STATUS, 1'b0, 32'h0, 32'h0, 2'h0},
            '{HWD_ADDR_TIMEOUT_SEL, 1'b1, 32'h0, 32'h0, 2'h0}};
        repeat (12) @(posedge core_clk_in);
        rst_in <= 1'b0;
        foreach (rows[i]) begin
            bus(rows[i].addr, rows[i].wr, rows[i].data);
            check(rs === rows[i].exp_resp, "bus response");
            if (!rows[i].wr) check(rd === rows[i].exp_rd, "read data");
        end
        quiet(16500);
        // Enable, then a write that is not a key must not stop it
        key();
        bus(HWD_ADDR_SERVICE_KEY, 1'b1, 32'h0);
        bus(HWD_ADDR_STATUS, 1'b0, 32'h0);
        check(rd[HWD_ST_ENABLED] === 1'b1, "running after key");
        // Periodic service: without the restarts the pulse would start about 8000 cycles before the checked window
        repeat (2) begin
            quiet(4000);
            key();
        end
        wait_pulse(16376, 16392);
        bus(HWD_ADDR_STATUS, 1'b0, 32'h0);
        check(rd === 32'h0, "off after overflow pulse");
        // Power-down with the wake pin held low freezes the count
        key();
        quiet(8000);
        // Strobe low for 50 cycles: the count must not advance
        @(posedge core_clk_in);
        machine_cycle_in <= 1'b0;
        quiet(50);
        @(posedge core_clk_in);
        machine_cycle_in <= 1'b1;
        @(posedge core_clk_in);
        power_down_in <= 1'b1;
        wake_int_n_in <= 1'b0;
        quiet(100);
        @(posedge core_clk_in);
        power_down_in <= 1'b0;
        quiet(2000);
        @(posedge core_clk_in);
        wake_int_n_in <= 1'b1;
        wait_pulse(8372, 8400);
        // Reset in mid-run, then the doubled timeout of select value one
        bus(HWD_ADDR_TIMEOUT_SEL, 1'b1, 32'h1);
        key();
        quiet(1000);
        @(posedge core_clk_in);
        rst_in <= 1'b1;
        repeat (2) @(posedge core_clk_in);
        rst_in <= 1'b0;
        bus(HWD_ADDR_TIMEOUT_SEL, 1'b0, 32'h0);
        check(rd === 32'h0, "select cleared by reset");
        bus(HWD_ADDR_STATUS, 1'b0, 32'h0);
        check(rd === 32'h0, "off after reset");
        bus(HWD_ADDR_TIMEOUT_SEL, 1'b1, 32'h1);
        key();
        wait_pulse(32760, 32776);
        stop_test();
    end
endmodule
`default_nettype wire
